// [core/ssc_pkg.sv]
package ssc_pkg;
  // ----------------------------------------------------------------
  // command codes and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] SSC_CMD_RESET = 8'h1E;
  localparam logic [7:0] SSC_CMD_RESULT = 8'h00;
  localparam logic [2:0] SSC_CONV_PREFIX = 3'h2;   // bits 7:5 of a conversion code
  localparam logic [3:0] SSC_CAL_PREFIX = 4'hA;    // bits 7:4 of a memory read code
  localparam int SSC_TYPE_BIT = 4;                 // 0 pressure, 1 temperature
  localparam int SSC_FIELD_LSB = 1;                // ratio or memory address, 3 bits
  localparam logic [2:0] SSC_RATIO_MAX = 3'h4;     // ratios 256 to 4096
  localparam logic [5:0] SSC_I2C_ADDR_HI = 6'h3B;  // upper six address bits 111011
  localparam int SSC_RES_W = 24;
  localparam int SSC_CAL_W = 16;
  localparam int SSC_CAL_WORDS = 8;
  localparam logic [3:0] SSC_BYTE_BITS = 4'h8;

  // ----------------------------------------------------------------
  // calibration memory locations and contents (values arbitrary)
  // ----------------------------------------------------------------
  localparam logic [2:0] SSC_FACTORY_SETUP_WORD = 3'h0;
  localparam logic [2:0] SSC_CAL_COEFF_ONE = 3'h1;
  localparam logic [2:0] SSC_CAL_COEFF_TWO = 3'h2;
  localparam logic [2:0] SSC_CAL_COEFF_THREE = 3'h3;
  localparam logic [2:0] SSC_CAL_COEFF_FOUR = 3'h4;
  localparam logic [2:0] SSC_CAL_COEFF_FIVE = 3'h5;
  localparam logic [2:0] SSC_CAL_COEFF_SIX = 3'h6;
  localparam logic [2:0] SSC_SERIAL_AND_CHECK_WORD = 3'h7;
  localparam logic [3:0] SSC_CHECK_CODE = 4'h5;       // arbitrary
  localparam logic [11:0] SSC_SERIAL_CODE = 12'h123;  // arbitrary
  localparam logic [7:0][15:0] SSC_CAL_ROM = {
    {SSC_SERIAL_CODE, SSC_CHECK_CODE},
    16'h6666, 16'h5555, 16'h4444, 16'h3333, 16'h2222, 16'h1111, 16'h0F0F
  };

  // ----------------------------------------------------------------
  // two-wire receiver states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    SSC_IDLE = 6'h01,
    SSC_ADDR = 6'h02,
    SSC_DACK = 6'h04,
    SSC_CMD = 6'h08,
    SSC_RD = 6'h10,
    SSC_HACK = 6'h20
  } ssc_i2c_e;
endpackage

// [core/ssc_command_unit.sv]
`timescale 1ns/100ps
`default_nettype none
module ssc_command_unit (
  input wire logic CORE_CLK,                   // core clock, 50 MHz
  input wire logic RESET,                      // synchronous, active high
  input wire logic SCLK,                       // serial clock from host
  input wire logic SERIAL_IN,                  // data in / two-wire data level
  input wire logic CHIP_SELECT_N,              // select, or address strap
  input wire logic PROTOCOL_STRAP,             // low four-wire, high two-wire
  output logic SERIAL_OUT,                     // four-wire data out
  output logic SDA_OUT,                        // two-wire drive level
  output logic SDA_OE,                         // two-wire drive enable
  output logic CONV_START,                     // converter start pulse
  output logic CONV_TYPE,                      // 0 pressure, 1 temperature
  output logic [2:0] CONV_RATIO,               // oversampling ratio code
  output logic CONV_ABORT,                     // converter abort pulse
  input wire logic CONV_DONE,                  // converter done pulse
  input wire logic [ssc_pkg::SSC_RES_W-1:0] CONV_DATA  // converter result
);
  import ssc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sclk_s1, sclk_s2, sclk_d;
    logic sda_s1, sda_s2, sda_d;
    logic cs_s1, cs_s2;
    logic ps_s1, ps_s2;
    ssc_i2c_e ist;
    logic [3:0] bitc;
    logic [7:0] rx;
    logic [23:0] tx;
    logic [23:0] pend;
    logic rw;
    logic busy, valid, bad;
    logic [23:0] result;
    logic [7:0][15:0] cal;
    logic sout, sda_oe, sda_lvl;
    logic conv_start, conv_type, conv_abort;
    logic [2:0] conv_ratio;
  } ssc_state_s;

  ssc_state_s st_reg, st_next;
  logic rise, fall, start_c, stop_c, i2c, fire;
  logic [7:0] cbyte;

  function automatic logic is_conv(input logic [7:0] b);
    is_conv = b[7:5] == SSC_CONV_PREFIX && !b[0] &&
              b[SSC_FIELD_LSB +: 3] <= SSC_RATIO_MAX;
  endfunction

  function automatic logic is_cal(input logic [7:0] b);
    is_cal = b[7:4] == SSC_CAL_PREFIX && !b[0];
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // pins pass two flops; edges are found on the second
  always_comb begin
    st_next = st_reg;
    st_next.sclk_s1 = SCLK;
    st_next.sclk_s2 = st_reg.sclk_s1;
    st_next.sclk_d = st_reg.sclk_s2;
    st_next.sda_s1 = SERIAL_IN;
    st_next.sda_s2 = st_reg.sda_s1;
    st_next.sda_d = st_reg.sda_s2;
    st_next.cs_s1 = CHIP_SELECT_N;
    st_next.cs_s2 = st_reg.cs_s1;
    st_next.ps_s1 = PROTOCOL_STRAP;
    st_next.ps_s2 = st_reg.ps_s1;
    st_next.conv_start = 1'b0;
    st_next.conv_abort = 1'b0;
    st_next.sda_lvl = 1'b0;
    rise = st_reg.sclk_s2 & ~st_reg.sclk_d;
    fall = ~st_reg.sclk_s2 & st_reg.sclk_d;
    i2c = st_reg.ps_s2;
    start_c = i2c & st_reg.sclk_s2 & st_reg.sclk_d & st_reg.sda_d & ~st_reg.sda_s2;
    stop_c = i2c & st_reg.sclk_s2 & st_reg.sclk_d & ~st_reg.sda_d & st_reg.sda_s2;
    fire = 1'b0;
    cbyte = st_reg.rx;

    if (!i2c) begin
      // four-wire: sample on rise, shift on fall, so modes 0 and 3 both fit
      st_next.ist = SSC_IDLE;
      st_next.sda_oe = 1'b0;
      if (st_reg.cs_s2) begin
        st_next.bitc = 4'h0;
        st_next.tx = '0;
        st_next.sout = 1'b0;
      end else begin
        if (rise && st_reg.bitc != SSC_BYTE_BITS) begin
          st_next.rx = {st_reg.rx[6:0], st_reg.sda_s2};
          st_next.bitc = st_reg.bitc + 4'h1;
          if (st_reg.bitc == SSC_BYTE_BITS - 4'h1) begin
            fire = 1'b1;
            cbyte = {st_reg.rx[6:0], st_reg.sda_s2};
          end
        end
        if (fall) begin
          st_next.sout = st_reg.tx[23];
          st_next.tx = {st_reg.tx[22:0], 1'b0};
        end
      end
    end else begin
      st_next.sout = 1'b0;
      unique case (st_reg.ist)
        SSC_ADDR, SSC_CMD: begin
          if (rise && st_reg.bitc != SSC_BYTE_BITS) begin
            st_next.rx = {st_reg.rx[6:0], st_reg.sda_s2};
            st_next.bitc = st_reg.bitc + 4'h1;
          end
          if (fall && st_reg.bitc == SSC_BYTE_BITS) begin
            st_next.bitc = 4'h0;
            if (st_reg.ist == SSC_CMD) begin
              fire = 1'b1;
              st_next.sda_oe = 1'b1;
              st_next.ist = SSC_DACK;
            end else if (st_reg.rx[7:1] == {SSC_I2C_ADDR_HI, ~st_reg.cs_s2}) begin
              st_next.rw = st_reg.rx[0];
              st_next.sda_oe = 1'b1;
              st_next.ist = SSC_DACK;
            end else begin
              st_next.ist = SSC_IDLE;
            end
          end
        end
        SSC_DACK: begin
          if (fall) begin
            if (st_reg.rw) begin
              st_next.sda_oe = ~st_reg.pend[23];
              st_next.tx = {st_reg.pend[22:0], 1'b0};
              st_next.bitc = 4'h1;
              st_next.ist = SSC_RD;
            end else begin
              st_next.sda_oe = 1'b0;
              st_next.ist = SSC_CMD;
            end
          end
        end
        SSC_RD: begin
          if (fall) begin
            if (st_reg.bitc == SSC_BYTE_BITS) begin
              st_next.sda_oe = 1'b0;
              st_next.bitc = 4'h0;
              st_next.ist = SSC_HACK;
            end else begin
              st_next.sda_oe = ~st_reg.tx[23];
              st_next.tx = {st_reg.tx[22:0], 1'b0};
              st_next.bitc = st_reg.bitc + 4'h1;
            end
          end
        end
        SSC_HACK: begin
          if (rise) begin
            st_next.rx = {st_reg.rx[6:0], st_reg.sda_s2};
          end
          if (fall) begin
            // a missing acknowledge ends the read
            if (!st_reg.rx[0]) begin
              st_next.sda_oe = ~st_reg.tx[23];
              st_next.tx = {st_reg.tx[22:0], 1'b0};
              st_next.bitc = 4'h1;
              st_next.ist = SSC_RD;
            end else begin
              st_next.ist = SSC_IDLE;
            end
          end
        end
        default: begin
          st_next.ist = SSC_IDLE;
          st_next.sda_oe = 1'b0;
        end
      endcase
      // start always wins, freeing a line held in an acknowledge
      if (start_c) begin
        st_next.ist = SSC_ADDR;
        st_next.bitc = 4'h0;
        st_next.sda_oe = 1'b0;
      end else if (stop_c) begin
        st_next.ist = SSC_IDLE;
        st_next.sda_oe = 1'b0;
      end
    end

    // converter end; select level plays no part here
    if (st_reg.busy && CONV_DONE) begin
      st_next.busy = 1'b0;
      st_next.valid = !st_reg.bad;
      st_next.result = st_reg.bad ? '0 : CONV_DATA;
    end

    // command execution, shared by both protocols
    if (fire) begin
      if (cbyte == SSC_CMD_RESET) begin
        st_next.conv_abort = 1'b1;
        st_next.busy = 1'b0;
        st_next.valid = 1'b0;
        st_next.bad = 1'b0;
        st_next.cal = SSC_CAL_ROM;
        st_next.pend = '0;
      end else if (cbyte == SSC_CMD_RESULT) begin
        // a result is handed out once only
        st_next.pend = (st_reg.valid && !st_reg.busy) ? st_reg.result : '0;
        st_next.valid = 1'b0;
        if (st_reg.busy) begin
          st_next.bad = 1'b1;
        end
      end else if (is_conv(cbyte)) begin
        st_next.conv_start = 1'b1;
        st_next.conv_type = cbyte[SSC_TYPE_BIT];
        st_next.conv_ratio = cbyte[SSC_FIELD_LSB +: 3];
        st_next.busy = 1'b1;
        st_next.valid = 1'b0;
        st_next.bad = 1'b0;
        st_next.pend = '0;
      end else if (is_cal(cbyte)) begin
        st_next.pend = {st_reg.cal[cbyte[SSC_FIELD_LSB +: 3]], 8'h00};
      end else begin
        st_next.pend = '0;
      end
      if (!i2c) begin
        st_next.tx = st_next.pend;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset loads the memory image as the power-on load would
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      st_reg <= '0;
      st_reg.ist <= SSC_IDLE;
      st_reg.cal <= SSC_CAL_ROM;
      // syncs rest high like an idle two-wire bus; four-wire is deselected then
      st_reg.sclk_s1 <= 1'b1;
      st_reg.sclk_s2 <= 1'b1;
      st_reg.sclk_d <= 1'b1;
      st_reg.sda_s1 <= 1'b1;
      st_reg.sda_s2 <= 1'b1;
      st_reg.sda_d <= 1'b1;
      st_reg.cs_s1 <= 1'b1;
      st_reg.cs_s2 <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign SERIAL_OUT = st_reg.sout;
  assign SDA_OUT = st_reg.sda_lvl;
  assign SDA_OE = st_reg.sda_oe;
  assign CONV_START = st_reg.conv_start;
  assign CONV_TYPE = st_reg.conv_type;
  assign CONV_RATIO = st_reg.conv_ratio;
  assign CONV_ABORT = st_reg.conv_abort;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  conv_start_a: assert property (fire && is_conv(cbyte) |=>
    CONV_START && CONV_TYPE == $past(cbyte[4]) && st_reg.busy)
    else $error("conversion command did not start converter");
  read_zero_a: assert property (fire && cbyte == SSC_CMD_RESULT &&
    (!st_reg.valid || st_reg.busy) |=> st_reg.pend == 24'h000000 && !st_reg.valid)
    else $error("result read without fresh result not zero");
  read_busy_a: assert property (fire && cbyte == SSC_CMD_RESULT && st_reg.busy &&
    !CONV_DONE |=> st_reg.bad ##0 (st_reg.busy && !fire) [*1] ##1 1'b1)
    else $error("read during conversion did not spoil result");
  cal_read_a: assert property (fire && is_cal(cbyte) |=>
    st_reg.pend == {SSC_CAL_ROM[$past(cbyte[3:1])], 8'h00})
    else $error("memory read returned wrong word");
  reset_cmd_a: assert property (fire && cbyte == SSC_CMD_RESET |=>
    CONV_ABORT && !st_reg.busy && st_reg.cal == SSC_CAL_ROM)
    else $error("reset command did not abort and reload");
  done_load_a: assert property (st_reg.busy && CONV_DONE && !st_reg.bad && !fire |=>
    st_reg.valid && st_reg.result == $past(CONV_DATA))
    else $error("finished conversion not made readable");
  foreign_addr_a: assert property (i2c && st_reg.ist == SSC_ADDR && fall &&
    st_reg.bitc == 4'h8 && st_reg.rx[7:1] != {SSC_I2C_ADDR_HI, ~st_reg.cs_s2} &&
    !start_c && !stop_c |=> !SDA_OE && st_reg.ist == SSC_IDLE)
    else $error("foreign address was acknowledged");
  byte_pause_a: assert property (i2c && st_reg.ist == SSC_RD && fall &&
    st_reg.bitc == 4'h8 && !start_c && !stop_c |=> st_reg.ist == SSC_HACK && !SDA_OE)
    else $error("no pause for host acknowledge");
  spi_shift_a: assert property (!i2c && !st_reg.cs_s2 && fall |=>
    SERIAL_OUT == $past(st_reg.tx[23]))
    else $error("four-wire output not shifted MSB first");
  select_idle_a: assert property (!i2c && st_reg.cs_s2 |=>
    st_reg.bitc == 4'h0 && !SERIAL_OUT)
    else $error("interface active while deselected");
  // two-wire answer path and converter strobes
  addr_ack_a: assert property (i2c && st_reg.ist == SSC_ADDR && fall &&
    st_reg.bitc == 4'h8 && st_reg.rx[7:1] == {SSC_I2C_ADDR_HI, ~st_reg.cs_s2} |=> SDA_OE)
    else $error("own address was not acknowledged");
  read_shift_a: assert property (i2c && st_reg.ist == SSC_RD && fall &&
    st_reg.bitc != 4'h8 |=> SDA_OE == !$past(st_reg.tx[23]))
    else $error("two-wire read bit not driven in order");
  ratio_legal_a: assert property (CONV_START |-> CONV_RATIO <= SSC_RATIO_MAX)
    else $error("converter started with illegal ratio");
  abort_once_a: assert property (CONV_ABORT |=> !CONV_ABORT)
    else $error("abort strobe stood too long");

  // main scenarios reached
  spi_conv_c: cover property (!i2c && fire && is_conv(cbyte) ##[1:1000] CONV_DONE);
  i2c_read_c: cover property (i2c && st_reg.ist == SSC_HACK ##[1:1000] st_reg.ist == SSC_RD);
  cal_c: cover property (i2c && fire && is_cal(cbyte));
  reset_cmd_c: cover property (fire && cbyte == SSC_CMD_RESET);
  busy_read_c: cover property (fire && cbyte == SSC_CMD_RESULT && st_reg.busy);
endmodule
`default_nettype wire

// [sim/ssc_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module ssc_host_model (
  input wire logic clk,     // core clock, paces the host
  input wire logic sda_oe,  // device pulls two-wire data low
  input wire logic sout,    // four-wire data from device
  output logic sclk,        // serial clock
  output logic sin,         // data in, or resolved two-wire level
  output logic csn,         // select, or address strap
  output logic strap        // protocol strap
);
  logic mosi = 1'b0;
  logic pull = 1'b0;
  // two-wire line has a pull-up: low while either party pulls it
  assign sin = strap ? ~(pull | sda_oe) : mosi;
  // idle: four-wire, deselected
  initial begin
    sclk = 1'b0;
    csn = 1'b1;
    strap = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // two-wire idles with clock high; settle the strap sync first
  task automatic setup(input logic two_wire, input logic cs);
    cyc(1);
    strap <= two_wire;
    csn <= cs;
    sclk <= two_wire;
    cyc(8);
  endtask
  // ----------------------------------------------------------------
  // four-wire frame: command byte, then nrd data bits read back
  // ----------------------------------------------------------------
  task automatic spi(input logic [7:0] cmd, input int nrd, input logic cpol,
                     output logic [23:0] rd);
    rd = '0;
    cyc(1);
    sclk <= cpol;
    cyc(4);
    csn <= 1'b0;
    cyc(4);
    for (int i = 0; i < 8 + nrd; i++) begin
      sclk <= 1'b0;
      mosi <= (i < 8) ? cmd[7 - i] : 1'b0;
      cyc(4);
      sclk <= 1'b1;
      cyc(3);
      // sample late in the high phase, well clear of the shift
      @(negedge clk);
      if (i >= 8) rd = {rd[22:0], sout};
      cyc(1);
    end
    sclk <= cpol;
    cyc(4);
    csn <= 1'b1;
    cyc(4);
  endtask
  // ----------------------------------------------------------------
  // two-wire framing and one byte plus acknowledge slot
  // ----------------------------------------------------------------
  task automatic i2c_start;
    pull <= 1'b0;
    cyc(3);
    sclk <= 1'b1;
    cyc(3);
    pull <= 1'b1;
    cyc(3);
    sclk <= 1'b0;
    cyc(3);
  endtask
  task automatic i2c_stop;
    pull <= 1'b1;
    cyc(3);
    sclk <= 1'b1;
    cyc(3);
    pull <= 1'b0;
    cyc(6);
  endtask
  // recovery: n bare clocks with the line released, for the device to let go
  task automatic i2c_clocks(input int n);
    cyc(1);
    pull <= 1'b0;
    repeat (n) begin
      cyc(4);
      sclk <= 1'b1;
      cyc(4);
      sclk <= 1'b0;
    end
    cyc(4);
  endtask
  // a 1 in tx releases the line, so the device may answer there
  task automatic i2c_byte(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      pull <= ~tx[i];
      cyc(3);
      sclk <= 1'b1;
      cyc(3);
      @(negedge clk);
      rx[i] = sin;
      cyc(1);
      sclk <= 1'b0;
      cyc(1);
    end
  endtask
endmodule
`default_nettype wire

// [sim/ssc_command_unit_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module ssc_command_unit_bench;
  import ssc_pkg::*;
  logic CORE_CLK = 1'b0;
  logic RESET = 1'b1;
  logic CONV_DONE = 1'b0;
  logic [SSC_RES_W-1:0] CONV_DATA = '0;
  logic SCLK, SERIAL_IN, CHIP_SELECT_N, PROTOCOL_STRAP, SERIAL_OUT, SDA_OUT, SDA_OE;
  logic CONV_START, CONV_TYPE, CONV_ABORT;
  logic [2:0] CONV_RATIO;
  logic [3:0] last_conv = '0;
  logic [23:0] rd;
  logic [8:0] rx;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int starts = 0;
  int aborts = 0;
  always #10 CORE_CLK = ~CORE_CLK;
  ssc_command_unit u_ssc_command_unit (.CORE_CLK(CORE_CLK), .RESET(RESET), .SCLK(SCLK),
    .SERIAL_IN(SERIAL_IN), .CHIP_SELECT_N(CHIP_SELECT_N), .PROTOCOL_STRAP(PROTOCOL_STRAP),
    .SERIAL_OUT(SERIAL_OUT), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .CONV_START(CONV_START),
    .CONV_TYPE(CONV_TYPE), .CONV_RATIO(CONV_RATIO), .CONV_ABORT(CONV_ABORT),
    .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA));
  ssc_host_model u_ssc_host_model (.clk(CORE_CLK), .sda_oe(SDA_OE), .sout(SERIAL_OUT),
    .sclk(SCLK), .sin(SERIAL_IN), .csn(CHIP_SELECT_N), .strap(PROTOCOL_STRAP));
  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic results;
    $display("checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  // converter watch and hang guard; ceiling well above the planned run
  always @(posedge CORE_CLK) begin
    cycles <= cycles + 1;
    if (CONV_START === 1'b1) begin
      starts <= starts + 1;
      last_conv <= {CONV_TYPE, CONV_RATIO};
    end
    if (CONV_ABORT === 1'b1) aborts <= aborts + 1;
    if (cycles == 40000) begin
      failures++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // shared drivers
  // ----------------------------------------------------------------
  task automatic frame(input logic [7:0] cmd, input int n, input logic cpol,
                       input logic [23:0] exp);
    u_ssc_host_model.spi(cmd, n, cpol, rd);
    chk(rd, exp);
    chk({23'h0, SERIAL_OUT}, 24'h0);
  endtask
  task automatic convert_done(input logic [23:0] d);
    @(posedge CORE_CLK);
    CONV_DONE <= 1'b1;
    CONV_DATA <= d;
    @(posedge CORE_CLK);
    CONV_DONE <= 1'b0;
  endtask
  task automatic xb(input logic [8:0] tx, input logic [8:0] exp);
    u_ssc_host_model.i2c_byte(tx, rx);
    chk({15'h0, rx}, {15'h0, exp});
  endtask
  task automatic wr_txn(input logic [7:0] cmd);
    u_ssc_host_model.i2c_start();
    xb({8'hEE, 1'b1}, {8'hEE, 1'b0});
    xb({cmd, 1'b1}, {cmd, 1'b0});
    u_ssc_host_model.i2c_stop();
  endtask
  // host acknowledges every byte but the last
  task automatic rd_txn(input int n, input logic [23:0] exp);
    u_ssc_host_model.i2c_start();
    xb({8'hEF, 1'b1}, {8'hEF, 1'b0});
    for (int b = n - 1; b >= 0; b--) begin
      xb({8'hFF, b == 0}, {exp[8 * b +: 8], b == 0});
    end
    u_ssc_host_model.i2c_stop();
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_memory;
    for (int a = 0; a < SSC_CAL_WORDS; a++) begin
      frame({SSC_CAL_PREFIX, a[2:0], 1'b0}, 16, a[0], {8'h0, SSC_CAL_ROM[a]});
    end
    chk({20'h0, rd[3:0]}, {20'h0, SSC_CHECK_CODE});
  endtask
  task automatic t_busy;
    frame(8'h00, 24, 1'b0, 24'h0);
    frame(8'h58, 0, 1'b1, 24'h0);
    frame(8'h00, 24, 1'b0, 24'h0);
    convert_done(24'h123456);
    frame(8'h00, 24, 1'b1, 24'h0);
  endtask
  // every code of both kinds, each finished before the next
  task automatic t_convert;
    logic [7:0] cmd;
    int s0;
    s0 = starts;
    for (int k = 0; k < 10; k++) begin
      cmd = 8'h40 + 8'(k / 5) * 8'h10 + 8'(k % 5) * 8'h02;
      frame(cmd, 0, k[0], 24'h0);
      chk({20'h0, last_conv}, {20'h0, 1'(k / 5), 3'(k % 5)});
      chk(24'(starts - s0), 24'(k + 1));
      convert_done({cmd, ~cmd, 8'h5A});
      frame(8'h00, 24, k[1], {cmd, ~cmd, 8'h5A});
      frame(8'h00, 24, k[0], 24'h0);
    end
  endtask
  task automatic t_reset;
    int a0;
    a0 = aborts;
    frame(8'h44, 0, 1'b0, 24'h0);
    frame(SSC_CMD_RESET, 0, 1'b1, 24'h0);
    chk(24'(aborts - a0), 24'h1);
    convert_done(24'hABCDEF);
    frame(8'h00, 24, 1'b0, 24'h0);
    frame(8'hA2, 16, 1'b1, {8'h0, SSC_CAL_ROM[1]});
  endtask
  task automatic t_two_wire;
    int a0;
    u_ssc_host_model.setup(1'b1, 1'b0);
    u_ssc_host_model.i2c_start();
    xb({8'hEC, 1'b1}, {8'hEC, 1'b1});
    u_ssc_host_model.i2c_stop();
    wr_txn(8'hA2);
    rd_txn(2, {8'h0, SSC_CAL_ROM[1]});
    wr_txn(8'h48);
    chk({20'h0, last_conv}, 24'h4);
    convert_done(24'hB1C2D3);
    wr_txn(SSC_CMD_RESULT);
    rd_txn(3, 24'hB1C2D3);
    a0 = aborts;
    wr_txn(SSC_CMD_RESET);
    chk(24'(aborts - a0), 24'h1);
    // host walks away mid-read with the line held low, then recovers it
    u_ssc_host_model.i2c_start();
    xb({8'hEF, 1'b1}, {8'hEF, 1'b0});
    u_ssc_host_model.cyc(4);
    @(negedge CORE_CLK);
    chk({23'h0, SDA_OE}, 24'h1);
    u_ssc_host_model.i2c_clocks(9);
    @(negedge CORE_CLK);
    chk({22'h0, SDA_OE, SDA_OUT}, 24'h0);
    u_ssc_host_model.cyc(1);
    u_ssc_host_model.i2c_stop();
    a0 = aborts;
    wr_txn(SSC_CMD_RESET);
    chk(24'(aborts - a0), 24'h1);
  endtask
  // main sequence: reset held for three cycles, then the scenarios
  initial begin
    repeat (3) @(posedge CORE_CLK);
    RESET <= 1'b0;
    repeat (4) @(posedge CORE_CLK);
    t_memory();
    t_busy();
    t_convert();
    t_reset();
    t_two_wire();
    results();
  end
endmodule
`default_nettype wire
